// [hw/ewsg_pkg.sv]
// constants, space codes and sequencer states of the external wait-state generator
package ewsg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // wait-state control register
  localparam logic [15:0] EWSG_WSC_ADDR = 16'hffff;   // topmost i/o address
  localparam int EWSG_WSC_WIDTH = 4;                  // implemented bits
  localparam int EWSG_PROG_WAIT_BIT = 0;              // program_space_wait
  localparam int EWSG_DATA_WAIT_BIT = 1;              // data_space_wait
  localparam int EWSG_IO_WAIT_BIT = 2;                // io_space_wait
  localparam int EWSG_TRACE_BIT = 3;                  // address_trace_enable
  localparam logic [3:0] EWSG_WSC_RESET = 4'hf;       // all bits set by reset
  localparam logic [11:0] EWSG_WSC_RSVD = 12'h000;    // bits 15..4 read as zero

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int EWSG_WRITE_MIN_CYCLES = 2;           // least write length
  localparam int EWSG_SOFT_WAITS = 1;                 // wait states per set bit

  ////////////////////////////////////////////////////////////////////////
  // address spaces
  typedef logic [1:0] ewsg_space_t;
  localparam ewsg_space_t EWSG_SP_PROG = 2'h0;
  localparam ewsg_space_t EWSG_SP_DATA = 2'h1;
  localparam ewsg_space_t EWSG_SP_IO = 2'h2;

  // bus sequencer states
  typedef enum logic [3:0] {
    EWSG_IDLE = 4'h1,
    EWSG_WRITE = 4'h2,
    EWSG_READ = 4'h4,
    EWSG_FETCH = 4'h8
  } ewsg_state_e;

endpackage

// [hw/ewsg_timer_if.sv]
// handshake between bus sequencer and access-length timer
`timescale 1ns/1ps
interface ewsg_timer_if;
  logic start;      // first cycle of a new access follows
  logic soft_wait;  // software wait state applies to it
  logic is_write;   // access is a write
  logic ready;      // filtered ready level
  logic done;       // access ends this cycle

  modport owner (output start, output soft_wait, output is_write, output ready, input done);
  modport timer (input start, input soft_wait, input is_write, input ready, output done);
endinterface

// [hw/ewsg_timer.sv]
// access-length timer: software wait, write minimum, then ready
`timescale 1ns/1ps
module ewsg_timer (
  input wire logic clk_sys,
  input wire logic rst_any_n,
  ewsg_timer_if.timer t
);
  import ewsg_pkg::*;

  logic busy_q, busy_d;   // access in progress
  logic need_q, need_d;   // access needs a second cycle
  logic past_q, past_d;   // first cycle elapsed

  //////////////////////////////////////////////////////////////////////////
  // next values
  always_comb begin
    busy_d = busy_q;
    need_d = need_q;
    past_d = past_q;
    if (t.start) begin
      // writes take at least two cycles whatever the bits say
      busy_d = 1'b1;
      need_d = t.soft_wait | t.is_write;
      past_d = 1'b0;
    end else if (t.done) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      // each wait state is one whole cycle
      past_d = 1'b1;
    end
  end

  // ready sampled only once the soft wait elapsed; cannot shorten it
  assign t.done = busy_q & (past_q | ~need_q) & t.ready;

  //////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys or negedge rst_any_n) begin
    if (!rst_any_n) begin
      busy_q <= 1'b0;
      need_q <= 1'b0;
      past_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      need_q <= need_d;
      past_q <= past_d;
    end
  end
endmodule

// [hw/ewsg_top.sv]
// external bus sequencer with software wait-state generator
// Notes on behaviour
// - set space bit inserts wait ignoring ready
// - ready low stretches access after soft wait
// - bit 0 adds one wait to program reads
// - bit 1 adds one wait to data reads
// - bit 2 adds one wait to off-chip i/o reads
// - external writes last at least two cycles
// - ready never shortens a software wait state
// - trace bit shows program address when bus idle
// - strobes stay inactive while tracing
// - reset sets all four control bits
// - reserved bits 15..4 read as zero
// - register decoded at topmost i/o address
// - either reset input alone resets block
// - reset aborts a write in progress
// - ready adds any number of whole-cycle waits
// - order write, then read, then fetch
// - internal register access also waits for ready
`timescale 1ns/1ps
module ewsg_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reset_in,
  // cpu side: one machine cycle of requests
  input wire logic cyc_start,
  input wire logic cyc_write,
  input wire ewsg_pkg::ewsg_space_t cyc_wr_space,
  input wire logic [15:0] cyc_wr_addr,
  input wire logic [15:0] cyc_wr_data,
  input wire logic cyc_read,
  input wire ewsg_pkg::ewsg_space_t cyc_rd_space,
  input wire logic [15:0] cyc_rd_addr,
  input wire logic cyc_fetch,
  input wire logic [15:0] cyc_fetch_addr,
  input wire logic [15:0] prog_addr,
  output logic cyc_busy_q,
  output logic cyc_done_q,
  output logic [15:0] rd_result_q,
  output logic [15:0] fetch_result_q,
  // external parallel bus pins
  output logic [15:0] bus_addr_q,
  input wire logic [15:0] bus_data_in,
  output logic [15:0] bus_data_out_q,
  output logic bus_data_oe_q,
  output logic prog_sel_n_q,
  output logic data_sel_n_q,
  output logic io_sel_n_q,
  output logic strobe_n_q,
  output logic read_n_q,
  output logic write_n_q,
  output logic read_not_write_q,
  input wire logic ready
);
  import ewsg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset and ready conditioning

  logic rst_any_n;  // either input resets, no synchroniser
  assign rst_any_n = rst_n & ~reset_in;

  logic [2:0] rdy_sync_q;  // three-stage pin sampler
  logic rdy_q, rdy_d;      // filtered ready level

  // accept a change once stages two and three agree
  always_comb begin
    rdy_d = rdy_q;
    if (rdy_sync_q[1] == rdy_sync_q[2]) begin
      rdy_d = rdy_sync_q[2];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_any_n) begin
    if (!rst_any_n) begin
      rdy_sync_q <= 3'h0;
      rdy_q <= 1'b0;
    end else begin
      rdy_sync_q <= {rdy_sync_q[1:0], ready};
      rdy_q <= rdy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  ewsg_state_e state_q, state_d;          // bus sequencer
  logic [2:0] pend_q, pend_d;             // pending write, read, fetch
  ewsg_space_t wr_sp_q, wr_sp_d;          // latched write space
  ewsg_space_t rd_sp_q, rd_sp_d;          // latched read space
  logic [15:0] wr_addr_q, wr_addr_d;
  logic [15:0] wr_data_q, wr_data_d;
  logic [15:0] rd_addr_q, rd_addr_d;
  logic [15:0] fe_addr_q, fe_addr_d;
  logic [3:0] wsc_q, wsc_d;               // wait_state_control bits
  logic [15:0] rd_res_d, fe_res_d;        // captured results
  logic done_d;                           // end-of-cycle pulse

  // pin next values
  logic [15:0] addr_d, dout_d;
  logic oe_d, psel_d, dsel_d, isel_d, strb_d, rdn_d, wen_d, rnw_d;

  ewsg_timer_if tif ();

  ewsg_timer u_timer (
    .clk_sys(clk_sys),
    .rst_any_n(rst_any_n),
    .t(tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // next access in fixed order
  function automatic ewsg_state_e pick(input logic [2:0] p);
    ewsg_state_e s;
    s = EWSG_IDLE;
    if (p[2]) begin
      s = EWSG_WRITE;
    end else if (p[1]) begin
      s = EWSG_READ;
    end else if (p[0]) begin
      s = EWSG_FETCH;
    end
    return s;
  endfunction

  // register hit: topmost i/o address
  function automatic logic is_reg(input ewsg_space_t sp, input logic [15:0] a);
    return (sp == EWSG_SP_IO) && (a == EWSG_WSC_ADDR);
  endfunction

  // software wait for an off-chip read of a space
  function automatic logic soft_of(input ewsg_space_t sp, input logic [3:0] w);
    logic r;
    r = 1'b0;
    if (sp == EWSG_SP_PROG) begin
      r = w[EWSG_PROG_WAIT_BIT];
    end else if (sp == EWSG_SP_DATA) begin
      r = w[EWSG_DATA_WAIT_BIT];
    end else if (sp == EWSG_SP_IO) begin
      r = w[EWSG_IO_WAIT_BIT];
    end
    return r;
  endfunction

  logic wr_int, rd_int;  // current write/read hits the register
  assign wr_int = is_reg(wr_sp_d, wr_addr_d);
  assign rd_int = is_reg(rd_sp_d, rd_addr_d);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next values

  always_comb begin
    state_d = state_q;
    pend_d = pend_q;
    wr_sp_d = wr_sp_q;
    rd_sp_d = rd_sp_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    rd_addr_d = rd_addr_q;
    fe_addr_d = fe_addr_q;
    wsc_d = wsc_q;
    rd_res_d = rd_result_q;
    fe_res_d = fetch_result_q;
    done_d = 1'b0;
    tif.start = 1'b0;
    unique case (state_q)
      EWSG_IDLE: begin
        // take a new machine cycle of requests
        if (cyc_start) begin
          pend_d = {cyc_write, cyc_read, cyc_fetch};
          wr_sp_d = cyc_wr_space;
          rd_sp_d = cyc_rd_space;
          wr_addr_d = cyc_wr_addr;
          wr_data_d = cyc_wr_data;
          rd_addr_d = cyc_rd_addr;
          fe_addr_d = cyc_fetch_addr;
          state_d = pick(pend_d);
          done_d = (state_d == EWSG_IDLE);
        end
      end
      EWSG_WRITE: begin
        // register writes also wait for ready
        if (tif.done) begin
          pend_d[2] = 1'b0;
          if (is_reg(wr_sp_q, wr_addr_q)) begin
            wsc_d = wr_data_q[EWSG_WSC_WIDTH-1:0];
          end
          state_d = pick(pend_d);
          done_d = (state_d == EWSG_IDLE);
        end
      end
      EWSG_READ: begin
        // reserved bits return zero on register reads
        if (tif.done) begin
          pend_d[1] = 1'b0;
          if (is_reg(rd_sp_q, rd_addr_q)) begin
            rd_res_d = {EWSG_WSC_RSVD, wsc_q};
          end else begin
            rd_res_d = bus_data_in;
          end
          state_d = pick(pend_d);
          done_d = (state_d == EWSG_IDLE);
        end
      end
      EWSG_FETCH: begin
        // fetch is last of the cycle
        if (tif.done) begin
          pend_d[0] = 1'b0;
          fe_res_d = bus_data_in;
          state_d = EWSG_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
    // every new access restarts the timer
    if (state_d != EWSG_IDLE && (state_d != state_q || tif.done)) begin
      tif.start = 1'b1;
    end
  end

  // timer inputs for the access being entered
  always_comb begin
    tif.is_write = (state_d == EWSG_WRITE);
    tif.ready = rdy_q;
    tif.soft_wait = 1'b0;
    if (state_d == EWSG_READ) begin
      tif.soft_wait = ~rd_int & soft_of(rd_sp_d, wsc_q);
    end else if (state_d == EWSG_FETCH) begin
      tif.soft_wait = soft_of(EWSG_SP_PROG, wsc_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin next values

  always_comb begin
    addr_d = bus_addr_q;
    dout_d = bus_data_out_q;
    oe_d = 1'b0;
    psel_d = 1'b1;
    dsel_d = 1'b1;
    isel_d = 1'b1;
    strb_d = 1'b1;
    rdn_d = 1'b1;
    wen_d = 1'b1;
    rnw_d = 1'b1;
    unique case (state_d)
      EWSG_IDLE: begin
        // trace: program address out, strobes quiet
        if (wsc_q[EWSG_TRACE_BIT]) begin
          addr_d = prog_addr;
        end
      end
      EWSG_WRITE: begin
        // external write drives data bus
        addr_d = wr_addr_d;
        dout_d = wr_data_d;
        rnw_d = 1'b0;
        if (!wr_int) begin
          oe_d = 1'b1;
          strb_d = 1'b0;
          wen_d = 1'b0;
          psel_d = (wr_sp_d != EWSG_SP_PROG);
          dsel_d = (wr_sp_d != EWSG_SP_DATA);
          isel_d = (wr_sp_d != EWSG_SP_IO);
        end
      end
      EWSG_READ: begin
        // program, data or i/o read
        addr_d = rd_addr_d;
        if (!rd_int) begin
          strb_d = 1'b0;
          rdn_d = 1'b0;
          psel_d = (rd_sp_d != EWSG_SP_PROG);
          dsel_d = (rd_sp_d != EWSG_SP_DATA);
          isel_d = (rd_sp_d != EWSG_SP_IO);
        end
      end
      EWSG_FETCH: begin
        // program fetch
        addr_d = fe_addr_d;
        strb_d = 1'b0;
        rdn_d = 1'b0;
        psel_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; async reset drops strobes at once, aborting writes

  always_ff @(posedge clk_sys or negedge rst_any_n) begin
    if (!rst_any_n) begin
      state_q <= EWSG_IDLE;
      pend_q <= 3'h0;
      wr_sp_q <= EWSG_SP_PROG;
      rd_sp_q <= EWSG_SP_PROG;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 16'h0000;
      rd_addr_q <= 16'h0000;
      fe_addr_q <= 16'h0000;
      wsc_q <= EWSG_WSC_RESET;
      cyc_done_q <= 1'b0;
      rd_result_q <= 16'h0000;
      fetch_result_q <= 16'h0000;
      bus_addr_q <= 16'h0000;
      bus_data_out_q <= 16'h0000;
      bus_data_oe_q <= 1'b0;
      prog_sel_n_q <= 1'b1;
      data_sel_n_q <= 1'b1;
      io_sel_n_q <= 1'b1;
      strobe_n_q <= 1'b1;
      read_n_q <= 1'b1;
      write_n_q <= 1'b1;
      read_not_write_q <= 1'b1;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      wr_sp_q <= wr_sp_d;
      rd_sp_q <= rd_sp_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      rd_addr_q <= rd_addr_d;
      fe_addr_q <= fe_addr_d;
      wsc_q <= wsc_d;
      cyc_done_q <= done_d;
      rd_result_q <= rd_res_d;
      fetch_result_q <= fe_res_d;
      bus_addr_q <= addr_d;
      bus_data_out_q <= dout_d;
      bus_data_oe_q <= oe_d;
      prog_sel_n_q <= psel_d;
      data_sel_n_q <= dsel_d;
      io_sel_n_q <= isel_d;
      strobe_n_q <= strb_d;
      read_n_q <= rdn_d;
      write_n_q <= wen_d;
      read_not_write_q <= rnw_d;
    end
  end

  // busy mirrors the sequencer state
  always_ff @(posedge clk_sys or negedge rst_any_n) begin
    if (!rst_any_n) begin
      cyc_busy_q <= 1'b0;
    end else begin
      cyc_busy_q <= (state_d != EWSG_IDLE);
    end
  end

endmodule

// [sim/ewsg_checker.sv]
// pin-level assertions for the wait-state generator
`timescale 1ns/1ps
module ewsg_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reset_in,
  input wire logic cyc_start,
  input wire logic cyc_busy_q,
  input wire logic cyc_done_q,
  input wire logic bus_data_oe_q,
  input wire logic prog_sel_n_q,
  input wire logic data_sel_n_q,
  input wire logic io_sel_n_q,
  input wire logic strobe_n_q,
  input wire logic read_n_q,
  input wire logic write_n_q,
  input wire logic read_not_write_q,
  input wire logic ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n || reset_in);
  ////////////////////////////////////////////////////////////////////////
  // data pins driven exactly during a write, marked as write
  property p_oe_wr;
    bus_data_oe_q == !write_n_q && (write_n_q || !read_not_write_q);
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("data enable not tied to write");
  // write strobe low for two cycles at least
  property p_wr_min;
    $fell(write_n_q) |=> !write_n_q;
  endproperty
  a_wr_min: assert property (p_wr_min) else $error("write shorter than two cycles");
  // no strobe while the bus is idle or tracing
  property p_idle_quiet;
    !cyc_busy_q |-> strobe_n_q && read_n_q && write_n_q;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("strobe active while idle");
  // done only once the sequencer is idle
  property p_done_idle;
    cyc_done_q |-> !cyc_busy_q;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while busy");
  // a request taken while idle starts at once
  property p_start_taken;
    cyc_start && !cyc_busy_q |=> cyc_busy_q || cyc_done_q;
  endproperty
  a_start_taken: assert property (p_start_taken) else $error("request not taken");
  // one space selected at a time
  property p_sel_one;
    $onehot0({!prog_sel_n_q, !data_sel_n_q, !io_sel_n_q});
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("two spaces selected");
  // strobe goes with a space select
  property p_sel_strobe;
    strobe_n_q == (prog_sel_n_q && data_sel_n_q && io_sel_n_q);
  endproperty
  a_sel_strobe: assert property (p_sel_strobe) else $error("strobe without select");
  // either reset input quiets the bus
  property p_rst_quiet;
    disable iff (1'b0) (!rst_n || reset_in) |-> strobe_n_q && write_n_q && !cyc_busy_q && !bus_data_oe_q;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("bus active in reset");
  // ready held low keeps every access open
  property p_ready_hold;
    !ready [*5] |=> !cyc_done_q;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("access ended without ready");
endmodule

// [sim/ewsg_ext_mem.sv]
// external memory and i/o device on the parallel bus
`timescale 1ns/1ps
module ewsg_ext_mem (
  input wire logic clk_sys,
  input wire logic [15:0] bus_addr_q,
  input wire logic [15:0] bus_data_out_q,
  input wire logic read_n_q,
  input wire logic write_n_q,
  input wire logic stall,
  output logic [15:0] bus_data_in,
  output logic ready
);
  logic [15:0] mem [16]; // word i starts as a000 + i
  logic [15:0] last_q; // last word driven
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'(16'ha000 + i);
    end
    last_q = 16'h0;
  end
  // ready low for whole cycles while stalled
  assign ready = !stall;
  // released bus shows the inverse of the last word
  assign bus_data_in = read_n_q ? ~last_q : mem[bus_addr_q[3:0]];
  // capture writes, remember read words
  always @(posedge clk_sys) begin
    if (!write_n_q) begin
      mem[bus_addr_q[3:0]] <= bus_data_out_q;
    end
    if (!read_n_q) begin
      last_q <= mem[bus_addr_q[3:0]];
    end
  end
endmodule

// [sim/tb_top.sv]
// testbench of the wait-state generator
`timescale 1ns/1ps
module tb_top;
  import ewsg_pkg::*;
  logic clk_sys, rst_n, reset_in, cyc_start, cyc_write, cyc_read, cyc_fetch, stall, ready;
  ewsg_space_t cyc_wr_space, cyc_rd_space;
  logic [15:0] cyc_wr_addr, cyc_wr_data, cyc_rd_addr, cyc_fetch_addr, prog_addr, bus_data_in;
  logic cyc_busy_q, cyc_done_q, bus_data_oe_q, prog_sel_n_q, data_sel_n_q, io_sel_n_q;
  logic strobe_n_q, read_n_q, write_n_q, read_not_write_q;
  logic [15:0] rd_result_q, fetch_result_q, bus_addr_q, bus_data_out_q;
  logic [3:0] code, code_q;
  logic [3:0] ord [$]; // order of bus accesses
  int n_errors, num_checks;
  ewsg_top DUT (.clk_sys, .rst_n, .reset_in, .cyc_start, .cyc_write, .cyc_wr_space, .cyc_wr_addr,
    .cyc_wr_data, .cyc_read, .cyc_rd_space, .cyc_rd_addr, .cyc_fetch, .cyc_fetch_addr, .prog_addr,
    .cyc_busy_q, .cyc_done_q, .rd_result_q, .fetch_result_q, .bus_addr_q, .bus_data_in, .bus_data_out_q,
    .bus_data_oe_q, .prog_sel_n_q, .data_sel_n_q, .io_sel_n_q, .strobe_n_q, .read_n_q, .write_n_q,
    .read_not_write_q, .ready);
  ewsg_ext_mem u_mem (.clk_sys, .bus_addr_q, .bus_data_out_q, .read_n_q, .write_n_q, .stall,
    .bus_data_in, .ready);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // log each new access kind seen on the bus
  assign code = {~write_n_q, ~prog_sel_n_q, ~data_sel_n_q, ~io_sel_n_q};
  always @(posedge clk_sys) begin
    code_q <= code;
    if (code != 4'h0 && code != code_q) begin
      ord.push_back(code);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_len(input string nm, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      n_errors++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // one machine cycle; len counts edges from take to done
  task automatic mc(input logic w, input ewsg_space_t ws, input logic [15:0] wa, input logic [15:0] wd,
    input logic r, input ewsg_space_t rs, input logic [15:0] ra, input logic f, output int len);
    @(posedge clk_sys);
    cyc_start <= 1'b1;
    cyc_write <= w;
    cyc_wr_space <= ws;
    cyc_wr_addr <= wa;
    cyc_wr_data <= wd;
    cyc_read <= r;
    cyc_rd_space <= rs;
    cyc_rd_addr <= ra;
    cyc_fetch <= f;
    @(posedge clk_sys);
    cyc_start <= 1'b0;
    len = 0;
    do begin
      @(posedge clk_sys);
      #1;
      len++;
    end while (cyc_done_q !== 1'b1 && len < 100);
  endtask
  task automatic wreg(input logic [15:0] v);
    int n;
    mc(1'b1, EWSG_SP_IO, EWSG_WSC_ADDR, v, 1'b0, EWSG_SP_IO, 16'h0, 1'b0, n);
  endtask
  task automatic rreg(input logic [15:0] exp);
    int n;
    mc(1'b0, EWSG_SP_IO, 16'h0, 16'h0, 1'b1, EWSG_SP_IO, EWSG_WSC_ADDR, 1'b0, n);
    chk_val("wsc", exp, rd_result_q);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // one wait bit at a time against every space
  task automatic t_spaces;
    int n;
    for (int k = 0; k < 3; k++) begin
      wreg(16'(16'h1 << k));
      for (int s = 0; s < 3; s++) begin
        mc(1'b0, ewsg_space_t'(s), 16'h0, 16'h0, 1'b1, ewsg_space_t'(s), 16'(4 + s), 1'b0, n);
        chk_len("rd_len", (s == k) ? 2 : 1, n);
        chk_val("rd_data", 16'(16'ha004 + s), rd_result_q);
        mc(1'b1, ewsg_space_t'(s), 16'h0008, 16'h0, 1'b0, ewsg_space_t'(s), 16'h0, 1'b0, n);
        chk_len("wr_len", 2, n);
      end
    end
  endtask
  // ready held low stretches a soft-wait read
  task automatic t_stall;
    int n;
    wreg(16'h0002);
    @(posedge clk_sys);
    stall <= 1'b1;
    // let the ready filter settle low before the request
    repeat (3) @(posedge clk_sys);
    fork
      mc(1'b0, EWSG_SP_DATA, 16'h0, 16'h0, 1'b1, EWSG_SP_DATA, 16'h0009, 1'b0, n);
      begin
        repeat (8) @(posedge clk_sys);
        stall <= 1'b0;
      end
    join
    chk_len("stall_wait", 11, n);
    chk_val("stall_data", 16'ha009, rd_result_q);
  endtask
  // write, read and fetch in one machine cycle
  task automatic t_order;
    int n;
    wreg(16'h0000);
    ord.delete();
    mc(1'b1, EWSG_SP_DATA, 16'h0003, 16'hbeef, 1'b1, EWSG_SP_DATA, 16'h0003, 1'b1, n);
    chk_len("mc_len", 4, n);
    chk_val("rd_after_wr", 16'hbeef, rd_result_q);
    chk_val("fetch", 16'ha007, fetch_result_q);
    chk_val("order", 16'h0a24, {ord[0], ord[1], ord[2]});
  endtask
  // program address shown on an idle bus
  task automatic t_trace;
    wreg(16'h0008);
    @(posedge clk_sys);
    prog_addr <= 16'h1234;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_val("trace_addr", 16'h1234, bus_addr_q);
    chk_val("trace_strobe", 16'h1, {15'h0, strobe_n_q});
    wreg(16'h0000);
    @(posedge clk_sys);
    prog_addr <= 16'h5678;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_val("trace_off", 16'h0, {15'h0, bus_addr_q === 16'h5678});
  endtask
  // high-level reset alone, in mid-write
  task automatic t_abort;
    int n;
    fork
      mc(1'b1, EWSG_SP_DATA, 16'h000a, 16'h1111, 1'b0, EWSG_SP_DATA, 16'h0, 1'b0, n);
      begin
        repeat (3) @(posedge clk_sys);
        reset_in <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk_val("abort_wr", 16'h1, {15'h0, write_n_q});
        chk_val("abort_busy", 16'h0, {15'h0, cyc_busy_q});
        @(posedge clk_sys);
        reset_in <= 1'b0;
      end
    join
    rreg(16'h000f);
  endtask
  task automatic conclude;
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b1;
    reset_in = 1'b0;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    cyc_read = 1'b0;
    cyc_fetch = 1'b0;
    cyc_wr_space = EWSG_SP_PROG;
    cyc_rd_space = EWSG_SP_PROG;
    cyc_wr_addr = 16'h0;
    cyc_wr_data = 16'h0;
    cyc_rd_addr = 16'h0;
    cyc_fetch_addr = 16'h0007;
    prog_addr = 16'h0;
    stall = 1'b0;
    n_errors = 0;
    num_checks = 0;
    // a real falling edge, so the async reset acts before the first clock
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rreg(16'h000f);
    t_spaces();
    wreg(16'hfff5);
    rreg(16'h0005);
    t_stall();
    t_order();
    t_trace();
    t_abort();
    conclude();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end
endmodule
bind ewsg_top ewsg_checker u_chk (.clk_sys, .rst_n, .reset_in, .cyc_start, .cyc_busy_q, .cyc_done_q,
  .bus_data_oe_q, .prog_sel_n_q, .data_sel_n_q, .io_sel_n_q, .strobe_n_q, .read_n_q, .write_n_q,
  .read_not_write_q, .ready);
